/* File: verilog/smps_top.sv */
// Module: stop-mode power sequencer with APB register access
module smps_top (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_b_i,
	// APB slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// Core handshake, same clock
	input wire logic stop_instr_i,
	input wire logic por_i,
	// Wake sources from pins and always-on logic
	input wire logic ext_irq_pin_i,
	input wire logic ext_irq_pol_high_i,
	input wire logic rtw_irq_i,
	input wire logic kbd_irq_i,
	input wire logic lvw_irq_i,
	input wire logic reset_pin_b_i,
	// Power and restart controls
	output smps_pkg::smps_power_s power_o,
	output logic in_stop_o,
	output logic [1:0] stop_depth_o,
	output logic illegal_op_reset_o,
	output logic reset_restart_o,
	output logic isr_resume_o,
	output logic rtw_tick_o
);
	typedef enum logic [2:0] {
		ST_RUN,
		ST_STOP3,
		ST_STOP2,
		ST_STOP1,
		ST_WAKE_ISR,
		ST_WAKE_RESET
	} smps_state_e;

	smps_state_e state;
	logic [31:0] sys_opt;
	logic [31:0] pmc1;
	logic [1:0] pmc2_mode;
	logic ppd_flag;
	logic [31:0] wake_en;
	logic pin_hold;
	logic full_reset;
	logic [15:0] rtw_div;
	logic [4:0] wake_raw;
	logic [4:0] wake_sync;
	smps_pkg::smps_wake_s wk;
	smps_pkg::smps_depth_e next_depth;
	logic irq_asserted;
	logic acc;
	logic ack_write;
	logic stop2_wake;

	// Decode of the selected stop depth from power-down bits
	function automatic smps_pkg::smps_depth_e depth_of(input logic power_down_ctrl, input logic partial_power_down_ctrl);
		if (!power_down_ctrl) begin
			return smps_pkg::SMPS_STOP3;
		end else if (partial_power_down_ctrl) begin
			return smps_pkg::SMPS_STOP2;
		end else begin
			return smps_pkg::SMPS_STOP1;
		end
	endfunction

	// All wake inputs leave the core domain, so synchronise them
	assign wake_raw = {ext_irq_pin_i, rtw_irq_i, kbd_irq_i, lvw_irq_i, ~reset_pin_b_i};

	smps_sync #(
		.W(5)
	) u_sync (
		.clk_sys_i(clk_sys_i),
		.rst_b_i(rst_b_i),
		.async_i(wake_raw),
		.sync_o(wake_sync)
	);

	assign wk = smps_pkg::smps_wake_s'(wake_sync);
	assign next_depth = depth_of(pmc2_mode[1], pmc2_mode[0]);
	assign acc = psel_i && penable_i;
	assign ack_write = acc && pwrite_i && (paddr_i == smps_pkg::ADDR_PMC2)
		&& pwdata_i[smps_pkg::P2_PPD_ACK];

	// Enabled stop2 wakes only; a disabled source or an idle low-active pin must not set the flag
	assign stop2_wake = irq_asserted && wake_en[smps_pkg::WE_EXT_IRQ]
		|| wk.rtw && wake_en[smps_pkg::WE_RTW]
		|| wk.kbd && wake_en[smps_pkg::WE_KBD_S2];

	// Configured polarity outside stop1; stop1 forces active low
	always_comb begin
		if (state == ST_STOP1) begin
			irq_asserted = !wk.ext_irq;
		end else begin
			irq_asserted = ext_irq_pol_high_i ? wk.ext_irq : !wk.ext_irq;
		end
	end

	// Register writes; a stop2 wake reloads all of them to reset values
	always_ff @(posedge clk_sys_i) begin
		if (!rst_b_i || full_reset) begin
			sys_opt <= smps_pkg::RST_SYS_OPT;
			pmc1 <= smps_pkg::RST_PMC1;
			pmc2_mode <= smps_pkg::RST_PMC2[1:0];
			wake_en <= smps_pkg::RST_WAKE_EN;
		end else if (acc && pwrite_i) begin
			case (paddr_i)
				smps_pkg::ADDR_SYS_OPT: begin
					sys_opt <= {31'h0000_0000, pwdata_i[smps_pkg::SO_STOP_EN]};
				end
				smps_pkg::ADDR_PMC1: begin
					pmc1 <= {30'h0000_0000, pwdata_i[1:0]};
				end
				smps_pkg::ADDR_PMC2: begin
					pmc2_mode <= {pwdata_i[smps_pkg::P2_PDC], pwdata_i[smps_pkg::P2_PARTIAL_POWER_DOWN_CTRL]};
				end
				smps_pkg::ADDR_WAKE_EN: begin
					wake_en <= {26'h000_0000, pwdata_i[5:0]};
				end
				default: begin
				end
			endcase
		end
	end

	// Partial power-down flag survives the stop2 reload; power-on clears it
	always_ff @(posedge clk_sys_i) begin
		if (!rst_b_i || por_i) begin
			ppd_flag <= 1'b0;
		end else if (state == ST_STOP2 && stop2_wake) begin
			ppd_flag <= 1'b1;
		end else if (ack_write) begin
			ppd_flag <= 1'b0;
		end
	end

	// Pin latches hold from stop2 entry until software acknowledges
	always_ff @(posedge clk_sys_i) begin
		if (!rst_b_i || por_i) begin
			pin_hold <= 1'b0;
		end else if (state == ST_STOP2) begin
			pin_hold <= 1'b1;
		end else if (ack_write && state == ST_RUN) begin
			pin_hold <= 1'b0;
		end
	end

	// Sequencer
	always_ff @(posedge clk_sys_i) begin
		if (!rst_b_i) begin
			state <= ST_RUN;
			illegal_op_reset_o <= 1'b0;
			full_reset <= 1'b0;
		end else begin
			illegal_op_reset_o <= 1'b0;
			full_reset <= 1'b0;
			case (state)
				ST_RUN: begin
					if (stop_instr_i) begin
						if (!sys_opt[smps_pkg::SO_STOP_EN]) begin
							illegal_op_reset_o <= 1'b1;
						end else if (next_depth == smps_pkg::SMPS_STOP3) begin
							state <= ST_STOP3;
						end else if (pmc1[smps_pkg::P1_LVD_EN]) begin
							// Deep stop refused while voltage detect is live; falls to stop3
							state <= ST_STOP3;
						end else if (next_depth == smps_pkg::SMPS_STOP2) begin
							state <= ST_STOP2;
						end else begin
							state <= ST_STOP1;
						end
					end
				end
				ST_STOP3: begin
					if (wk.reset_pin) begin
						state <= ST_WAKE_RESET;
					end else if (irq_asserted && wake_en[smps_pkg::WE_EXT_IRQ]
						|| wk.rtw && wake_en[smps_pkg::WE_RTW]
						|| wk.kbd && wake_en[smps_pkg::WE_KBD]
						|| wk.low_voltage_warning && pmc1[smps_pkg::P1_LVW_IE]) begin
						state <= ST_WAKE_ISR;
					end
				end
				ST_STOP2: begin
					if (wk.reset_pin) begin
						state <= ST_WAKE_RESET;
					end else if (stop2_wake) begin
						state <= ST_WAKE_RESET;
					end
				end
				ST_STOP1: begin
					if (wk.reset_pin || irq_asserted && wake_en[smps_pkg::WE_EXT_IRQ]) begin
						state <= ST_WAKE_RESET;
					end
				end
				ST_WAKE_ISR: begin
					state <= ST_RUN;
				end
				ST_WAKE_RESET: begin
					full_reset <= 1'b1;
					state <= ST_RUN;
				end
				default: begin
					state <= ST_RUN;
				end
			endcase
		end
	end

	// Restart strobes to the core
	always_ff @(posedge clk_sys_i) begin
		if (!rst_b_i) begin
			reset_restart_o <= 1'b0;
			isr_resume_o <= 1'b0;
		end else begin
			reset_restart_o <= (state == ST_WAKE_RESET);
			isr_resume_o <= (state == ST_WAKE_ISR);
		end
	end

	// Power controls per depth
	always_ff @(posedge clk_sys_i) begin
		if (!rst_b_i) begin
			power_o <= '{core_clk_en: 1'b1, periph_en: 1'b1, rtw_run: 1'b0, rtw_ext_clk: 1'b0,
				osc_en: 1'b1, pin_latch: 1'b0, ram_pwr: 1'b1, logic_pwr: 1'b1};
			in_stop_o <= 1'b0;
			stop_depth_o <= 2'h0;
		end else begin
			// Latch in the same cycle stop2 is shown, not one cycle after the hold flop
			power_o.pin_latch <= pin_hold || (state == ST_STOP2);
			power_o.rtw_ext_clk <= 1'b0;
			case (state)
				ST_STOP3: begin
					power_o.core_clk_en <= 1'b0;
					power_o.periph_en <= 1'b0;
					power_o.rtw_run <= wake_en[smps_pkg::WE_RTW];
					power_o.osc_en <= wake_en[smps_pkg::WE_OSC_STOP];
					power_o.rtw_ext_clk <= wake_en[smps_pkg::WE_RTW_EXT]
						&& wake_en[smps_pkg::WE_OSC_STOP];
					power_o.ram_pwr <= 1'b1;
					power_o.logic_pwr <= 1'b1;
					in_stop_o <= 1'b1;
					stop_depth_o <= 2'(smps_pkg::SMPS_STOP3);
				end
				ST_STOP2: begin
					power_o.core_clk_en <= 1'b0;
					power_o.periph_en <= 1'b0;
					power_o.rtw_run <= wake_en[smps_pkg::WE_RTW];
					power_o.osc_en <= 1'b0;
					power_o.ram_pwr <= 1'b1;
					power_o.logic_pwr <= 1'b0;
					in_stop_o <= 1'b1;
					stop_depth_o <= 2'(smps_pkg::SMPS_STOP2);
				end
				ST_STOP1: begin
					power_o.core_clk_en <= 1'b0;
					power_o.periph_en <= 1'b0;
					power_o.rtw_run <= 1'b0;
					power_o.osc_en <= 1'b0;
					power_o.ram_pwr <= 1'b0;
					power_o.logic_pwr <= 1'b0;
					in_stop_o <= 1'b1;
					stop_depth_o <= 2'(smps_pkg::SMPS_STOP1);
				end
				default: begin
					power_o.core_clk_en <= 1'b1;
					power_o.periph_en <= 1'b1;
					power_o.rtw_run <= 1'b0;
					power_o.osc_en <= 1'b1;
					power_o.ram_pwr <= 1'b1;
					power_o.logic_pwr <= 1'b1;
					in_stop_o <= 1'b0;
					stop_depth_o <= 2'h0;
				end
			endcase
		end
	end

	// Internal 1 kHz time base for the wake timer; only ticks while it runs
	always_ff @(posedge clk_sys_i) begin
		if (!rst_b_i || !power_o.rtw_run || power_o.rtw_ext_clk) begin
			rtw_div <= 16'h0000;
			rtw_tick_o <= 1'b0;
		end else if (rtw_div == smps_pkg::RTW_DIV_LAST) begin
			rtw_div <= 16'h0000;
			rtw_tick_o <= 1'b1;
		end else begin
			rtw_div <= rtw_div + 16'h0001;
			rtw_tick_o <= 1'b0;
		end
	end

	// APB read data; zero wait states, unmapped reads zero with error
	always_ff @(posedge clk_sys_i) begin
		if (!rst_b_i) begin
			prdata_o <= 32'h0000_0000;
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
		end else begin
			pready_o <= psel_i && !penable_i;
			pslverr_o <= 1'b0;
			prdata_o <= 32'h0000_0000;
			if (psel_i && !penable_i) begin
				case (paddr_i)
					smps_pkg::ADDR_SYS_OPT: prdata_o <= sys_opt;
					smps_pkg::ADDR_PMC1: prdata_o <= pmc1;
					smps_pkg::ADDR_PMC2: begin
						prdata_o <= {28'h000_0000, ppd_flag, 1'b0, pmc2_mode};
					end
					smps_pkg::ADDR_STATUS: begin
						prdata_o <= {27'h000_0000, pin_hold, wk.reset_pin, 3'(state)};
					end
					smps_pkg::ADDR_WAKE_EN: prdata_o <= wake_en;
					default: pslverr_o <= 1'b1;
				endcase
			end
		end
	end
endmodule

/* File: verilog/smps_pkg.sv */
// Package: register map, field positions and types of the stop-mode power sequencer
package smps_pkg;
	// APB byte addresses
	localparam logic [7:0] ADDR_SYS_OPT = 8'h00;
	localparam logic [7:0] ADDR_PMC1 = 8'h04;
	localparam logic [7:0] ADDR_PMC2 = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0C;
	localparam logic [7:0] ADDR_WAKE_EN = 8'h10;
	// system_options_reg fields
	localparam int SO_STOP_EN = 0;
	// power_mgmt_ctrl1_reg fields
	localparam int P1_LVD_EN = 0;
	localparam int P1_LVW_IE = 1;
	// power_mgmt_ctrl2_reg fields
	localparam int P2_PARTIAL_POWER_DOWN_CTRL = 0;
	localparam int P2_PDC = 1;
	localparam int P2_PPD_ACK = 2;
	localparam int P2_PPD_FLAG = 3;
	// wake enable register fields
	localparam int WE_RTW = 0;
	localparam int WE_RTW_EXT = 1;
	localparam int WE_OSC_STOP = 2;
	localparam int WE_EXT_IRQ = 3;
	localparam int WE_KBD = 4;
	localparam int WE_KBD_S2 = 5;
	// Reset values
	localparam logic [31:0] RST_SYS_OPT = 32'h0000_0000;
	localparam logic [31:0] RST_PMC1 = 32'h0000_0001;
	localparam logic [31:0] RST_PMC2 = 32'h0000_0000;
	localparam logic [31:0] RST_WAKE_EN = 32'h0000_0000;
	// Internal rate of the wake-timer time base
	localparam int RTW_INT_HZ = 1000;
	localparam int CLK_HZ = 40000000;
	localparam int RTW_DIV = CLK_HZ / RTW_INT_HZ;
	localparam logic [15:0] RTW_DIV_LAST = 16'(RTW_DIV - 1);

	typedef enum logic [1:0] {
		SMPS_STOP3,
		SMPS_STOP2,
		SMPS_STOP1
	} smps_depth_e;

	// Wake sources, all synchronised levels
	typedef struct packed {
		logic ext_irq;
		logic rtw;
		logic kbd;
		logic low_voltage_warning;
		logic reset_pin;
	} smps_wake_s;

	// Retention controls seen by the rest of the chip
	typedef struct packed {
		logic core_clk_en;
		logic periph_en;
		logic rtw_run;
		logic rtw_ext_clk;
		logic osc_en;
		logic pin_latch;
		logic ram_pwr;
		logic logic_pwr;
	} smps_power_s;
endpackage

/* File: verilog/smps_sync.sv */
// Module: two-flop synchroniser for a bundle of asynchronous levels
module smps_sync #(
	parameter int W = 5
) (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_b_i,
	// Levels
	input wire logic [W-1:0] async_i,
	output logic [W-1:0] sync_o
);
	logic [W-1:0] stage1;

	always_ff @(posedge clk_sys_i) begin
		if (!rst_b_i) begin
			stage1 <= '0;
			sync_o <= '0;
		end else begin
			stage1 <= async_i;
			sync_o <= stage1;
		end
	end
endmodule

/* File: bench/smps_monitor.sv */
// Checker of port timing for the stop-mode power sequencer
module smps_monitor (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_b_i,
	// Bus handshake
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pready_o,
	// Stop control and status
	input wire logic stop_instr_i,
	input wire smps_pkg::smps_power_s power_o,
	input wire logic in_stop_o,
	input wire logic [1:0] stop_depth_o,
	input wire logic illegal_op_reset_o,
	input wire logic reset_restart_o,
	input wire logic isr_resume_o,
	input wire logic rtw_tick_o
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!rst_b_i);
	// Depth means nothing while running, so gate it with in_stop_o
	wire logic s2 = in_stop_o && stop_depth_o == 2'h1;
	wire logic s1 = in_stop_o && stop_depth_o == 2'h2;
	wire logic s3 = in_stop_o && stop_depth_o == 2'h0;
	a_illegal_cause:
		assert property (illegal_op_reset_o |-> $past(stop_instr_i) && !in_stop_o)
		else $error("illegal reset without stop request");
	a_illegal_no_entry:
		assert property (illegal_op_reset_o |=> !in_stop_o [*2])
		else $error("stop entered after illegal reset");
	a_entry_cause:
		assert property ($rose(in_stop_o) |-> $past(stop_instr_i, 2))
		else $error("stop entered without request");
	a_stop3_retain:
		assert property (s3 |-> power_o.ram_pwr && power_o.logic_pwr && !power_o.periph_en)
		else $error("stop3 retention wrong");
	a_stop2_latch:
		assert property (s2 |-> power_o.pin_latch && power_o.ram_pwr && !power_o.osc_en
			&& !power_o.rtw_ext_clk && !power_o.periph_en)
		else $error("stop2 power wrong");
	a_stop1_off:
		assert property (s1 |-> !power_o.periph_en && !power_o.core_clk_en)
		else $error("stop1 not off");
	a_isr_stop3_only:
		assert property (isr_resume_o |-> $past(in_stop_o) && $past(stop_depth_o) == 2'h0)
		else $error("handler resume not from stop3");
	a_restart_from_stop:
		assert property (reset_restart_o |-> $past(in_stop_o))
		else $error("restart without stop");
	a_one_wake_pulse:
		assert property (isr_resume_o |-> !reset_restart_o ##1 !isr_resume_o)
		else $error("resume pulse malformed");
	a_bus_ready:
		assert property (psel_i && penable_i |-> pready_o)
		else $error("no ready in access phase");
	a_tick_gap:
		assert property (rtw_tick_o |=> !rtw_tick_o [*8])
		else $error("wake timer ticks too close");
	c_isr: cover property (isr_resume_o);
	c_stop2_wake: cover property (reset_restart_o && $past(stop_depth_o) == 2'h1);
	c_illegal: cover property (illegal_op_reset_o);
endmodule

/* File: bench/tb_top.sv */
// Testbench: directed stop, wake and register scenarios for the sequencer
`define CHK(n, e, a) begin \
	compares++; \
	if ((a) !== (e)) begin \
		bad_count++; \
		$display("BAD %s exp %0h got %0h", n, e, a); \
	end \
end
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_sys_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic psel_i = 1'b0;
	logic penable_i = 1'b0;
	logic pwrite_i = 1'b0;
	logic [7:0] paddr_i = 8'h00;
	logic [31:0] pwdata_i = 32'h0000_0000;
	logic stop_instr_i = 1'b0;
	logic [4:0] wk = 5'h00;
	logic [31:0] prdata_o;
	logic pready_o, pslverr_o, in_stop_o, illegal_op_reset_o;
	logic reset_restart_o, isr_resume_o, rtw_tick_o;
	logic [1:0] stop_depth_o;
	smps_pkg::smps_power_s power_o;
	int bad_count = 0;
	int compares = 0;
	logic [31:0] q;
	logic e;
	always #12.5 clk_sys_i = ~clk_sys_i;
	smps_top i_dut (
		.clk_sys_i,
		.rst_b_i,
		.psel_i,
		.penable_i,
		.pwrite_i,
		.paddr_i,
		.pwdata_i,
		.prdata_o,
		.pready_o,
		.pslverr_o,
		.stop_instr_i,
		.por_i(1'b0),
		.ext_irq_pin_i(wk[3]),
		.ext_irq_pol_high_i(1'b1),
		.rtw_irq_i(wk[0]),
		.kbd_irq_i(wk[1]),
		.lvw_irq_i(wk[2]),
		.reset_pin_b_i(!wk[4]),
		.power_o,
		.in_stop_o,
		.stop_depth_o,
		.illegal_op_reset_o,
		.reset_restart_o,
		.isr_resume_o,
		.rtw_tick_o
	);
	task end_sim;
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_sys_i);
		penable_i <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_sys_i);
			n++;
		end while (pready_o !== 1'b1 && n < 20);
		if (n >= 20) begin
			bad_count++;
			end_sim();
		end
		q = prdata_o;
		e = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		@(posedge clk_sys_i);
	endtask
	task stop(input logic [1:0] dep);
		stop_instr_i <= 1'b1;
		@(posedge clk_sys_i);
		stop_instr_i <= 1'b0;
		repeat (2) @(posedge clk_sys_i);
		#1;
		`CHK("in_stop", 1'b1, in_stop_o)
		`CHK("depth", dep, stop_depth_o)
	endtask
	// Each wake source is released again one cycle after the handler-resume or restart pulse is seen
	task wake(input logic [4:0] v, input logic isr);
		int n;
		@(posedge clk_sys_i);
		wk <= v;
		n = 0;
		do begin
			@(posedge clk_sys_i);
			#1;
			n++;
		end while (!(isr_resume_o | reset_restart_o) && n < 20);
		if (!(isr_resume_o | reset_restart_o)) begin
			bad_count++;
			end_sim();
		end
		`CHK("isr", isr, isr_resume_o)
		`CHK("restart", !isr, reset_restart_o)
		@(posedge clk_sys_i);
		wk <= 5'h00;
		@(posedge clk_sys_i);
	endtask
	task t_illegal;
		bus(1'b0, smps_pkg::ADDR_PMC1, 32'h0);
		`CHK("pmc1", smps_pkg::RST_PMC1, q)
		bus(1'b0, 8'h14, 32'h0);
		`CHK("unmapped", 1'b1, e)
		stop_instr_i <= 1'b1;
		@(posedge clk_sys_i);
		stop_instr_i <= 1'b0;
		#1;
		`CHK("illegal", 1'b1, illegal_op_reset_o)
		repeat (2) @(posedge clk_sys_i);
		#1;
		`CHK("no_stop", 1'b0, in_stop_o)
		@(posedge clk_sys_i);
		$display("illegal stop done");
	endtask
	// Counts edges up to the next wake timer tick
	task tick_wait(output int n);
		n = 0;
		do begin
			@(posedge clk_sys_i);
			#1;
			n++;
		end while (rtw_tick_o !== 1'b1 && n < smps_pkg::RTW_DIV + 8);
		if (rtw_tick_o !== 1'b1) begin
			bad_count++;
			end_sim();
		end
	endtask
	task t_stop3;
		int gap;
		bus(1'b1, smps_pkg::ADDR_SYS_OPT, 32'h1);
		bus(1'b1, smps_pkg::ADDR_PMC1, 32'h3);
		bus(1'b1, smps_pkg::ADDR_WAKE_EN, 32'h19);
		bus(1'b1, smps_pkg::ADDR_PMC2, 32'h3);
		for (int i = 0; i < 5; i++) begin
			stop(2'h0);
			`CHK("logic", 1'b1, power_o.logic_pwr)
			`CHK("periph", 1'b0, power_o.periph_en)
			`CHK("rtw_run", 1'b1, power_o.rtw_run)
			`CHK("ext_clk", 1'b0, power_o.rtw_ext_clk)
			if (i == 0) begin
				tick_wait(gap);
				tick_wait(gap);
				`CHK("tick_gap", smps_pkg::RTW_DIV, gap)
			end
			wake(5'h01 << i, i < 4);
		end
		$display("stop3 wakes done");
	endtask
	task t_stop2;
		bus(1'b1, smps_pkg::ADDR_SYS_OPT, 32'h1);
		bus(1'b1, smps_pkg::ADDR_PMC1, 32'h0);
		bus(1'b1, smps_pkg::ADDR_WAKE_EN, 32'h08);
		bus(1'b1, smps_pkg::ADDR_PMC2, 32'h3);
		stop(2'h1);
		`CHK("latch", 1'b1, power_o.pin_latch)
		`CHK("osc", 1'b0, power_o.osc_en)
		wake(5'h08, 1'b0);
		bus(1'b0, smps_pkg::ADDR_PMC2, 32'h0);
		`CHK("flag", 32'h8, q)
		bus(1'b0, smps_pkg::ADDR_WAKE_EN, 32'h0);
		`CHK("wake_en", smps_pkg::RST_WAKE_EN, q)
		`CHK("held", 1'b1, power_o.pin_latch)
		bus(1'b1, smps_pkg::ADDR_PMC2, 32'h4);
		bus(1'b0, smps_pkg::ADDR_PMC2, 32'h0);
		`CHK("ack", 32'h0, q)
		`CHK("freed", 1'b0, power_o.pin_latch)
		$display("stop2 wake done");
	endtask
	task t_stop1;
		wk <= 5'h08;
		bus(1'b1, smps_pkg::ADDR_SYS_OPT, 32'h1);
		bus(1'b1, smps_pkg::ADDR_PMC1, 32'h0);
		bus(1'b1, smps_pkg::ADDR_WAKE_EN, 32'h08);
		bus(1'b1, smps_pkg::ADDR_PMC2, 32'h2);
		stop(2'h2);
		repeat (10) @(posedge clk_sys_i);
		#1;
		`CHK("high_pin", 1'b1, in_stop_o)
		wake(5'h00, 1'b0);
		$display("stop1 wake done");
	endtask
	initial begin
		repeat (4) @(posedge clk_sys_i);
		rst_b_i <= 1'b1;
		@(posedge clk_sys_i);
		t_illegal();
		t_stop3();
		t_stop2();
		t_stop1();
		end_sim();
	end
endmodule
bind smps_top smps_monitor i_mon (
	.clk_sys_i,
	.rst_b_i,
	.psel_i,
	.penable_i,
	.pready_o,
	.stop_instr_i,
	.power_o,
	.in_stop_o,
	.stop_depth_o,
	.illegal_op_reset_o,
	.reset_restart_o,
	.isr_resume_o,
	.rtw_tick_o
);
